//--- hdl/ota_map.svh
`ifndef OTA_MAP_SVH
`define OTA_MAP_SVH

`define OTA_ADDR_HIGH      8'h00
`define OTA_ADDR_MID       8'h01
`define OTA_ADDR_LOW       8'h02
`define OTA_ADDR_FILTER    8'h03
`define OTA_ADDR_COL       8'h04
`define OTA_ADDR_ROW       8'h05
`define OTA_ADDR_WIDTH     8'h06
`define OTA_ADDR_HEIGHT    8'h07
`define OTA_ADDR_BOUND_HI  8'h08
`define OTA_ADDR_BOUND_LO  8'h09
`define OTA_ADDR_BACK_FAC  8'h0A
`define OTA_ADDR_FORE_FAC  8'h0B

`define OTA_MASK_BLINK     7
`define OTA_MASK_SHADOW    6
`define OTA_MASK_BACK      5
`define OTA_MASK_FORE      4
`define OTA_MASK_CODE      3
`define OTA_MODE_MSB       2

`define OTA_SEL_HIGH       2
`define OTA_SEL_MID        1
`define OTA_SEL_LOW        0

`define OTA_RST_FILTER     8'hFF
`define OTA_RST_WIDTH      8'h20
`define OTA_RST_HEIGHT     8'h10
`define OTA_RST_BOUND      9'h100
`define OTA_RST_FACTOR     8'h80
`define OTA_RST_BYTE       8'h00

`endif

//--- hdl/ota_pkg.sv
package ota_pkg;

  typedef enum logic [1:0] {
    OTA_BLINK_OFF,
    OTA_BLINK_FORE,
    OTA_STATIC_INVERSE,
    OTA_BLINK_SWAP
  } ota_blink_t;

  typedef struct packed {
    ota_blink_t  blink;
    logic        shadow;
    logic        back_transparent;
    logic        fore_transparent;
    logic        back_blend_enable;
    logic        fore_blend_enable;
    logic [2:0]  back_colour_index;
    logic [2:0]  fore_index_or_palette_sel;
    logic        from_rom;
    logic [8:0]  glyph_code;
  } ota_elem_t;

  typedef struct packed {
    ota_blink_t  blink;
    logic        fore_blinks;
    logic        inverse_static;
    logic        swap_blinks;
    logic        shadow;
    logic        back_transparent;
    logic        fore_transparent;
    logic        back_blend_enable;
    logic        fore_blend_enable;
    logic [2:0]  back_colour_index;
    logic [2:0]  fore_colour_index;
    logic [2:0]  palette_sel;
    logic        multicolour;
    logic        from_rom;
    logic [8:0]  glyph_code;
  } ota_render_t;

endpackage

//--- hdl/ota_attr_decode.sv
`timescale 1ns/10ps
`default_nettype none
module ota_attr_decode
  import ota_pkg::*;
(
  input  wire ota_elem_t   elem,
  input  wire logic [8:0]  boundary_code,
  output ota_render_t      render
);

  always_comb begin
    render                   = '0;
    render.blink             = elem.blink; // RL11
    render.fore_blinks       = (elem.blink == OTA_BLINK_FORE); // RL11
    render.inverse_static    = (elem.blink == OTA_STATIC_INVERSE); // RL11
    render.swap_blinks       = (elem.blink == OTA_BLINK_SWAP); // RL11
    render.shadow            = elem.shadow; // RL12
    render.back_transparent  = elem.back_transparent; // RL13
    render.fore_transparent  = elem.fore_transparent; // RL14
    render.back_blend_enable = elem.back_blend_enable; // RL15
    render.fore_blend_enable = elem.fore_blend_enable; // RL16
    render.back_colour_index = elem.back_colour_index; // RL7
    render.from_rom          = elem.from_rom; // RL17
    render.glyph_code        = elem.glyph_code; // RL18
    // Multicolour glyphs live only in font RAM, at or above the boundary
    render.multicolour = !elem.from_rom && (elem.glyph_code >= boundary_code); // RL10
    if (render.multicolour) begin
      render.palette_sel = elem.fore_index_or_palette_sel; // RL8
    end else begin
      render.fore_colour_index = elem.fore_index_or_palette_sel; // RL9
    end
  end

endmodule // ota_attr_decode
`default_nettype wire

//--- hdl/ota_char_attr.sv
// Operation
// RL1: Each commit moves cursor right, wrapping rows.
// RL2: Cursor column and row readable without side effects.
// RL3: Each element holds a 23-bit attribute word.
// RL4: Word assembled from high, middle, low registers.
// RL5: Attributes apply to their own cell only.
// RL6: Colour fields are table indices, not RGB.
// RL7: Background index picks one of eight colours.
// RL8: Multicolour: field picks one of eight palettes.
// RL9: Shared field: foreground index or palette number.
// RL10: Glyph code versus boundary decides multicolour.
// RL11: Blink field: off, fore, inverse, swap.
// RL12: Shadow bit draws one-pixel offset shadow.
// RL13: Background transparent bit hides background pixels.
// RL14: Foreground transparent bit hides foreground pixels.
// RL15: Background blend uses global background factor.
// RL16: Foreground blend uses global foreground factor.
// RL17: Font source bit: one ROM, zero RAM.
// RL18: Nine-bit glyph code split mid and low.
// RL19: Commit only after all active registers rewritten.
// RL20: Masked groups keep previous element value.
// RL21: Host keeps width times height within 1024.
// RL22: After last element, cursor wraps to origin.
`timescale 1ns/10ps
`default_nettype none
`include "ota_map.svh"
module ota_char_attr
  import ota_pkg::*;
#(
  parameter int ELEMENTS   = 1024,
  parameter int ADDR_WIDTH = 10
)(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  input  wire logic [ADDR_WIDTH-1:0] disp_addr,
  output ota_render_t                disp_attr,
  output logic      [7:0]            back_blend_factor,
  output logic      [7:0]            fore_blend_factor,
  output logic                       elem_commit
);

  logic [7:0]  char_attr_high;
  logic [7:0]  char_attr_mid;
  logic [7:0]  char_attr_low;
  logic [7:0]  attr_update_filter;
  logic [7:0]  write_cursor_column;
  logic [7:0]  write_cursor_row;
  logic [7:0]  window_width_chars;
  logic [7:0]  window_height_chars;
  logic [8:0]  multicolour_boundary_code;
  logic [2:0]  pending;
  logic [7:0]  next_char_attr_high;
  logic [7:0]  next_char_attr_mid;
  logic [7:0]  next_char_attr_low;
  logic [7:0]  next_attr_update_filter;
  logic [7:0]  next_write_cursor_column;
  logic [7:0]  next_write_cursor_row;
  logic [7:0]  next_window_width_chars;
  logic [7:0]  next_window_height_chars;
  logic [8:0]  next_multicolour_boundary_code;
  logic [7:0]  next_back_blend_factor;
  logic [7:0]  next_fore_blend_factor;
  logic [2:0]  next_pending;
  logic [7:0]  next_reg_rdata;
  logic [2:0]  write_mode;
  logic [2:0]  sel_hit;
  logic [2:0]  pend_all;
  logic        commit;
  logic        last_col;
  logic        last_row;
  logic [15:0] elem_index;
  logic [ADDR_WIDTH-1:0] wr_addr;
  ota_elem_t   new_elem;
  ota_elem_t   old_elem;
  ota_elem_t   merged;
  ota_render_t next_disp_attr;

  // Element store, no reset: contents are defined by the host
  ota_elem_t   window_mem [0:ELEMENTS-1]; // RL3

  assign write_mode = attr_update_filter[`OTA_MODE_MSB:0];

  assign sel_hit[`OTA_SEL_HIGH] = reg_wr && (reg_addr == `OTA_ADDR_HIGH);
  assign sel_hit[`OTA_SEL_MID]  = reg_wr && (reg_addr == `OTA_ADDR_MID);
  assign sel_hit[`OTA_SEL_LOW]  = reg_wr && (reg_addr == `OTA_ADDR_LOW);

  // Mode 000 activates nothing, so no element is ever stored
  assign pend_all = pending | (sel_hit & write_mode);
  assign commit   = (write_mode != 3'h0) && ((sel_hit & write_mode) != 3'h0) &&
                    ((pend_all & write_mode) == write_mode); // RL19
  assign elem_commit = commit;

  // New word taken from the freshly written byte where one lands now
  always_comb begin
    logic [7:0] hi;
    logic [7:0] mi;
    logic [7:0] lo;
    hi = sel_hit[`OTA_SEL_HIGH] ? reg_wdata : char_attr_high;
    mi = sel_hit[`OTA_SEL_MID]  ? reg_wdata : char_attr_mid;
    lo = sel_hit[`OTA_SEL_LOW]  ? reg_wdata : char_attr_low;
    new_elem = {hi[6:0], mi, lo}; // RL4 RL18
  end

  assign elem_index = write_cursor_row * window_width_chars + 16'(write_cursor_column);
  assign wr_addr    = elem_index[ADDR_WIDTH-1:0]; // RL21
  assign old_elem   = window_mem[wr_addr];

  always_comb begin
    merged = old_elem;
    if (attr_update_filter[`OTA_MASK_BLINK]) begin
      merged.blink = new_elem.blink; // RL20
    end
    if (attr_update_filter[`OTA_MASK_SHADOW]) begin
      merged.shadow = new_elem.shadow; // RL20
    end
    if (attr_update_filter[`OTA_MASK_BACK]) begin
      merged.back_transparent  = new_elem.back_transparent; // RL20
      merged.back_blend_enable = new_elem.back_blend_enable;
      merged.back_colour_index = new_elem.back_colour_index;
    end
    if (attr_update_filter[`OTA_MASK_FORE]) begin
      merged.fore_transparent          = new_elem.fore_transparent; // RL20
      merged.fore_blend_enable         = new_elem.fore_blend_enable;
      merged.fore_index_or_palette_sel = new_elem.fore_index_or_palette_sel;
    end
    if (attr_update_filter[`OTA_MASK_CODE]) begin
      merged.from_rom   = new_elem.from_rom; // RL20
      merged.glyph_code = new_elem.glyph_code;
    end
  end

  assign last_col = (write_cursor_column + 8'h01) >= window_width_chars;
  assign last_row = (write_cursor_row + 8'h01) >= window_height_chars;

  always_comb begin
    next_char_attr_high            = char_attr_high;
    next_char_attr_mid             = char_attr_mid;
    next_char_attr_low             = char_attr_low;
    next_attr_update_filter        = attr_update_filter;
    next_write_cursor_column       = write_cursor_column;
    next_write_cursor_row          = write_cursor_row;
    next_window_width_chars        = window_width_chars;
    next_window_height_chars       = window_height_chars;
    next_multicolour_boundary_code = multicolour_boundary_code;
    next_back_blend_factor         = back_blend_factor;
    next_fore_blend_factor         = fore_blend_factor;
    next_pending                   = pend_all & write_mode;
    if (reg_wr) begin
      case (reg_addr)
        `OTA_ADDR_HIGH:     next_char_attr_high = reg_wdata;
        `OTA_ADDR_MID:      next_char_attr_mid = reg_wdata;
        `OTA_ADDR_LOW:      next_char_attr_low = reg_wdata;
        `OTA_ADDR_FILTER: begin
          next_attr_update_filter = reg_wdata;
          next_pending            = 3'h0;
        end
        `OTA_ADDR_COL:      next_write_cursor_column = reg_wdata;
        `OTA_ADDR_ROW:      next_write_cursor_row = reg_wdata;
        `OTA_ADDR_WIDTH:    next_window_width_chars = reg_wdata;
        `OTA_ADDR_HEIGHT:   next_window_height_chars = reg_wdata;
        `OTA_ADDR_BOUND_HI: next_multicolour_boundary_code[8] = reg_wdata[0];
        `OTA_ADDR_BOUND_LO: next_multicolour_boundary_code[7:0] = reg_wdata;
        `OTA_ADDR_BACK_FAC: next_back_blend_factor = reg_wdata; // RL15
        `OTA_ADDR_FORE_FAC: next_fore_blend_factor = reg_wdata; // RL16
        default:            next_pending = pend_all & write_mode;
      endcase
    end
    if (commit) begin
      next_pending = 3'h0;
      if (!last_col) begin
        next_write_cursor_column = write_cursor_column + 8'h01; // RL1
      end else begin
        next_write_cursor_column = 8'h00; // RL1
        next_write_cursor_row    = last_row ? 8'h00 : write_cursor_row + 8'h01; // RL22
      end
    end
  end

  // Reads have no side effects on cursor or contents
  always_comb begin
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      case (reg_addr)
        `OTA_ADDR_HIGH:     next_reg_rdata = char_attr_high;
        `OTA_ADDR_MID:      next_reg_rdata = char_attr_mid;
        `OTA_ADDR_LOW:      next_reg_rdata = char_attr_low;
        `OTA_ADDR_FILTER:   next_reg_rdata = attr_update_filter;
        `OTA_ADDR_COL:      next_reg_rdata = write_cursor_column; // RL2
        `OTA_ADDR_ROW:      next_reg_rdata = write_cursor_row; // RL2
        `OTA_ADDR_WIDTH:    next_reg_rdata = window_width_chars;
        `OTA_ADDR_HEIGHT:   next_reg_rdata = window_height_chars;
        `OTA_ADDR_BOUND_HI: next_reg_rdata = {7'h00, multicolour_boundary_code[8]};
        `OTA_ADDR_BOUND_LO: next_reg_rdata = multicolour_boundary_code[7:0];
        `OTA_ADDR_BACK_FAC: next_reg_rdata = back_blend_factor;
        `OTA_ADDR_FORE_FAC: next_reg_rdata = fore_blend_factor;
        default:            next_reg_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      char_attr_high            <= `OTA_RST_BYTE;
      char_attr_mid             <= `OTA_RST_BYTE;
      char_attr_low             <= `OTA_RST_BYTE;
      attr_update_filter        <= `OTA_RST_FILTER;
      write_cursor_column       <= `OTA_RST_BYTE;
      write_cursor_row          <= `OTA_RST_BYTE;
      window_width_chars        <= `OTA_RST_WIDTH;
      window_height_chars       <= `OTA_RST_HEIGHT;
      multicolour_boundary_code <= `OTA_RST_BOUND;
      back_blend_factor         <= `OTA_RST_FACTOR;
      fore_blend_factor         <= `OTA_RST_FACTOR;
      pending                   <= 3'h0;
      reg_rdata                 <= `OTA_RST_BYTE;
      disp_attr                 <= '0;
    end else begin
      char_attr_high            <= next_char_attr_high;
      char_attr_mid             <= next_char_attr_mid;
      char_attr_low             <= next_char_attr_low;
      attr_update_filter        <= next_attr_update_filter;
      write_cursor_column       <= next_write_cursor_column;
      write_cursor_row          <= next_write_cursor_row;
      window_width_chars        <= next_window_width_chars;
      window_height_chars       <= next_window_height_chars;
      multicolour_boundary_code <= next_multicolour_boundary_code;
      back_blend_factor         <= next_back_blend_factor;
      fore_blend_factor         <= next_fore_blend_factor;
      pending                   <= next_pending;
      reg_rdata                 <= next_reg_rdata;
      disp_attr                 <= next_disp_attr;
    end
  end

  // Only the addressed element is touched
  always_ff @(posedge clk) begin
    if (commit) begin
      window_mem[wr_addr] <= merged; // RL5
    end
  end

  // Colour fields leave as indices; the colour tables sit elsewhere
  ota_attr_decode u_decode (
    .elem          (window_mem[disp_addr]),
    .boundary_code (multicolour_boundary_code),
    .render        (next_disp_attr)
  ); // RL6

  logic [ADDR_WIDTH-1:0] chk_addr;
  ota_elem_t             chk_elem;
  always_ff @(posedge clk) begin
    chk_addr <= wr_addr;
  end
  assign chk_elem = window_mem[chk_addr];

  property p_step_right;
    @(posedge clk) disable iff (rst)
    commit && !last_col |=> write_cursor_column == $past(write_cursor_column) + 8'h01;
  endproperty
  a_step_right: assert property (p_step_right) else $error("cursor did not step"); // RL1

  property p_row_wrap;
    @(posedge clk) disable iff (rst)
    commit && last_col && !last_row
      |=> write_cursor_column == 8'h00 && write_cursor_row == $past(write_cursor_row) + 8'h01;
  endproperty
  a_row_wrap: assert property (p_row_wrap) else $error("row wrap wrong"); // RL1

  property p_origin_wrap;
    @(posedge clk) disable iff (rst)
    commit && last_col && last_row |=> write_cursor_column == 8'h00 && write_cursor_row == 8'h00;
  endproperty
  a_origin_wrap: assert property (p_origin_wrap) else $error("no wrap to origin"); // RL22

  property p_read_cursor;
    @(posedge clk) disable iff (rst)
    reg_rd && !reg_wr && !commit && reg_addr == `OTA_ADDR_COL
      |=> reg_rdata == $past(write_cursor_column) && $stable(write_cursor_column);
  endproperty
  a_read_cursor: assert property (p_read_cursor) else $error("cursor read wrong"); // RL2

  property p_inactive_no_commit;
    @(posedge clk) disable iff (rst)
    reg_wr && reg_addr == `OTA_ADDR_HIGH && !write_mode[`OTA_SEL_HIGH] |-> !commit;
  endproperty
  a_inactive_no_commit: assert property (p_inactive_no_commit) else $error("bad commit"); // RL19

  property p_full_mode_order;
    @(posedge clk) disable iff (rst)
    write_mode == 3'h7 && sel_hit == 3'h1 && pending == 3'h6 |-> commit;
  endproperty
  a_full_mode_order: assert property (p_full_mode_order) else $error("commit missed"); // RL19

  property p_code_kept;
    @(posedge clk) disable iff (rst)
    commit && !attr_update_filter[`OTA_MASK_CODE]
      |=> chk_elem.glyph_code == $past(old_elem.glyph_code);
  endproperty
  a_code_kept: assert property (p_code_kept) else $error("masked code changed"); // RL20

  property p_code_written;
    @(posedge clk) disable iff (rst)
    commit && attr_update_filter[`OTA_MASK_CODE]
      |=> chk_elem.glyph_code == $past(new_elem.glyph_code);
  endproperty
  a_code_written: assert property (p_code_written) else $error("code not written"); // RL18

  property p_shared_field;
    @(posedge clk) disable iff (rst)
    !disp_attr.multicolour |-> disp_attr.palette_sel == 3'h0;
  endproperty
  a_shared_field: assert property (p_shared_field) else $error("palette on single"); // RL9

  property p_rom_single;
    @(posedge clk) disable iff (rst)
    disp_attr.from_rom |-> !disp_attr.multicolour;
  endproperty
  a_rom_single: assert property (p_rom_single) else $error("ROM glyph multicolour"); // RL10

endmodule // ota_char_attr
`default_nettype wire

//--- tb/ota_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module ota_host_model (
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       elem_commit
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // Idle bus shows inverted leftovers, so stale bytes are never trusted
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic done);
    @(negedge clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    #1 done = elem_commit;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask
endmodule // ota_host_model
`default_nettype wire

//--- tb/ota_char_attr_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "ota_map.svh"
`define OTA_EXPECT(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module ota_char_attr_test
  import ota_pkg::*;
;
  logic        clk, rst, reg_wr, reg_rd, elem_commit, c;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, back_blend_factor, fore_blend_factor, v;
  logic [9:0]  disp_addr;
  ota_render_t disp_attr;
  logic [22:0] mem_exp [6];
  logic [22:0] nw;
  int          num_errors, check_count;
  logic [7:0]  rst_img [13] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h20,
                                8'h10, 8'h01, 8'h00, 8'h80, 8'h80, 8'h00};

  initial clk = 1'b0;
  always #20 clk = ~clk;

  ota_char_attr u_ota_char_attr (
    .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .disp_addr(disp_addr),
    .disp_attr(disp_attr), .back_blend_factor(back_blend_factor),
    .fore_blend_factor(fore_blend_factor), .elem_commit(elem_commit)
  );

  ota_host_model u_ota_host_model (
    .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .elem_commit(elem_commit)
  );

  function automatic logic [22:0] mk(input logic [1:0] bl, input logic [4:0] fl,
                                     input logic [2:0] bk, input logic [2:0] fo,
                                     input logic rom, input logic [8:0] g);
    return {bl, fl, bk, fo, rom, g};
  endfunction

  function automatic ota_render_t dec(input logic [22:0] w, input logic [8:0] bound);
    ota_render_t r;
    r = '0;
    r.blink             = ota_blink_t'(w[22:21]);
    r.fore_blinks       = (w[22:21] == 2'b01);
    r.inverse_static    = (w[22:21] == 2'b10);
    r.swap_blinks       = (w[22:21] == 2'b11);
    r.shadow            = w[20];
    r.back_transparent  = w[19];
    r.fore_transparent  = w[18];
    r.back_blend_enable = w[17];
    r.fore_blend_enable = w[16];
    r.back_colour_index = w[15:13];
    r.from_rom          = w[9];
    r.glyph_code        = w[8:0];
    r.multicolour       = !w[9] && (w[8:0] >= bound);
    if (r.multicolour) begin
      r.palette_sel = w[12:10];
    end else begin
      r.fore_colour_index = w[12:10];
    end
    return r;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_ota_host_model.wr(a, d, c);
  endtask

  task automatic rd(input logic [7:0] a);
    u_ota_host_model.rd(a, v);
  endtask

  task automatic peek(input int i);
    @(negedge clk);
    disp_addr = 10'(i);
    @(negedge clk);
  endtask

  task automatic wrap_up;
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog: a hung bus cycle still reaches the verdict
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    rst       = 1'b1;
    disp_addr = '0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    foreach (rst_img[i]) begin
      rd(8'(i));
      `OTA_EXPECT(v, rst_img[i])
    end
    `OTA_EXPECT(back_blend_factor, 8'h80)
    `OTA_EXPECT(fore_blend_factor, 8'h80)
    // Small window so row and origin wrap come quickly
    wr(`OTA_ADDR_WIDTH, 8'h03);
    wr(`OTA_ADDR_HEIGHT, 8'h02);
    wr(`OTA_ADDR_BOUND_HI, 8'hFE);
    wr(`OTA_ADDR_BOUND_LO, 8'h80);
    rd(`OTA_ADDR_BOUND_HI);
    `OTA_EXPECT(v, 8'h00)
    wr(`OTA_ADDR_BACK_FAC, 8'h33);
    wr(`OTA_ADDR_FORE_FAC, 8'hC4);
    wr(8'h0C, 8'h5A);
    `OTA_EXPECT(back_blend_factor, 8'h33)
    `OTA_EXPECT(fore_blend_factor, 8'hC4)
    rd(8'h0C);
    `OTA_EXPECT(v, 8'h00)
    mem_exp[0] = mk(2'b00, 5'b11010, 3'h5, 3'h2, 1'b0, 9'h041);
    mem_exp[1] = mk(2'b01, 5'b00101, 3'h1, 3'h6, 1'b0, 9'h080);
    mem_exp[2] = mk(2'b10, 5'b01010, 3'h7, 3'h3, 1'b1, 9'h1FF);
    mem_exp[3] = mk(2'b11, 5'b10101, 3'h0, 3'h7, 1'b0, 9'h07F);
    mem_exp[4] = mk(2'b00, 5'b11111, 3'h3, 3'h4, 1'b0, 9'h100);
    mem_exp[5] = mk(2'b01, 5'b00000, 3'h6, 3'h1, 1'b1, 9'h0C5);
    for (int i = 0; i < 6; i++) begin
      wr(`OTA_ADDR_HIGH, {1'b1, mem_exp[i][22:16]});
      `OTA_EXPECT(c, 1'b0)
      wr(`OTA_ADDR_MID, mem_exp[i][15:8]);
      `OTA_EXPECT(c, 1'b0)
      wr(`OTA_ADDR_LOW, mem_exp[i][7:0]);
      `OTA_EXPECT(c, 1'b1)
      rd(`OTA_ADDR_COL);
      `OTA_EXPECT(v, 8'((i + 1) % 3))
      rd(`OTA_ADDR_ROW);
      `OTA_EXPECT(v, 8'(((i + 1) / 3) % 2))
    end
    rd(`OTA_ADDR_HIGH);
    `OTA_EXPECT(v, {1'b1, mem_exp[5][22:16]})
    for (int i = 0; i < 6; i++) begin
      peek(i);
      `OTA_EXPECT(disp_attr, dec(mem_exp[i], 9'h080))
    end
    // Masks: blink and back live; shadow, fore, code frozen; mid+low active
    wr(`OTA_ADDR_COL, 8'h01);
    wr(`OTA_ADDR_ROW, 8'h00);
    wr(`OTA_ADDR_FILTER, 8'hA3);
    nw = mk(2'b11, 5'b11111, 3'h2, 3'h5, 1'b1, 9'h1AA);
    wr(`OTA_ADDR_HIGH, {1'b0, nw[22:16]});
    `OTA_EXPECT(c, 1'b0)
    wr(`OTA_ADDR_MID, nw[15:8]);
    `OTA_EXPECT(c, 1'b0)
    wr(`OTA_ADDR_LOW, nw[7:0]);
    `OTA_EXPECT(c, 1'b1)
    mem_exp[1] = (nw & 23'b11010101110000000000000) | (mem_exp[1] & 23'b00101010001111111111111);
    peek(1);
    `OTA_EXPECT(disp_attr, dec(mem_exp[1], 9'h080))
    // Mode zero must never store
    wr(`OTA_ADDR_FILTER, 8'hF8);
    wr(`OTA_ADDR_LOW, 8'h11);
    `OTA_EXPECT(c, 1'b0)
    rd(`OTA_ADDR_COL);
    `OTA_EXPECT(v, 8'h02)
    // Low-only burst reuses the held high and mid bytes
    wr(`OTA_ADDR_FILTER, 8'hF9);
    for (int i = 2; i < 4; i++) begin
      wr(`OTA_ADDR_LOW, 8'(8'h30 + i));
      `OTA_EXPECT(c, 1'b1)
      mem_exp[i] = {nw[22:8], 8'(8'h30 + i)};
      peek(i);
      `OTA_EXPECT(disp_attr, dec(mem_exp[i], 9'h080))
    end
    rd(`OTA_ADDR_ROW);
    `OTA_EXPECT(v, 8'h01)
    wrap_up();
  end
endmodule // ota_char_attr_test
`default_nettype wire
